/* File: nvm_loader_defs.svh */
// Word offsets, field positions and default values for the NVM configuration loader
`ifndef NVM_LOADER_DEFS_SVH
`define NVM_LOADER_DEFS_SVH
`define W_ADDR_LO 6'h00
`define W_ADDR_HI 6'h02
`define W_SHARED_LAST 6'h18
`define W_PCI_INIT 6'h0a
`define W_SUBSYS_ID 6'h0b
`define W_SUBSYS_VEN 6'h0c
`define W_DEV_ID 6'h0d
`define W_POWER 6'h10
`define B_FETCH_DEV 0
`define B_FETCH_SUBSYS 1
`define B_WAKE_EN 6
`define B_AUXILIARY_POWER_FLAG 7
`define PCI_INIT_DEFAULT 16'h10c3
`define POWER_DEFAULT 16'h0702
`define SUBSYS_ID_DEFAULT 16'h0000
`define SEL_D0_A 3'h0
`define SEL_D0_B 3'h4
`define SEL_D3_A 3'h3
`define SEL_D3_B 3'h7
`define WAKE_SUPPORT_ALL 5'h0f
`define WAKE_SUPPORT_COLD 5'h10
`endif

/* File: nvm_loader_pkg.sv */
// Types for the NVM configuration loader
`default_nettype none
package nvm_loader_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_LO, ST_HI, ST_APPLY} load_state_t;
endpackage : nvm_loader_pkg
`default_nettype wire

/* File: nvm_byte_if.sv */
// Word read channel between the loader sequencer and the word fetcher
`timescale 1ns/1ns
`default_nettype none
interface nvm_byte_if;
  logic wordReq;
  logic [5:0] wordOffset;
  logic wordDone;
  logic [15:0] wordData;
  modport seq (output wordReq, output wordOffset, input wordDone, input wordData);
  modport fetch (input wordReq, input wordOffset, output wordDone, output wordData);
endinterface : nvm_byte_if
`default_nettype wire

/* File: nvm_word_fetch.sv */
// Assembles one 16-bit word from two byte reads of the NVM
`timescale 1ns/1ns
`default_nettype none
`include "nvm_loader_defs.svh"
module nvm_word_fetch
  import nvm_loader_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  nvm_byte_if.fetch wordPort,
  output logic byteRdReq,
  output logic [7:0] byteRdAddr,
  input wire logic byteRdValid,
  input wire logic [7:0] byteRdData
);
  logic busy_r;
  logic hiPhase_r;
  logic [7:0] addr_r;
  logic [7:0] lowByte_r;
  logic [15:0] data_r;
  logic done_r;
  logic [7:0] baseAddr;

  // Byte address is twice the word offset
  assign baseAddr = {1'b0, wordPort.wordOffset, 1'b0};
  assign byteRdReq = busy_r;
  assign byteRdAddr = addr_r;
  assign wordPort.wordDone = done_r;
  assign wordPort.wordData = data_r;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busy_r <= 1'b0;
      hiPhase_r <= 1'b0;
      addr_r <= 8'h00;
      lowByte_r <= 8'h00;
      data_r <= 16'h0000;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && wordPort.wordReq && !done_r) begin
        busy_r <= 1'b1;
        hiPhase_r <= 1'b0;
        addr_r <= baseAddr;
      end else if (busy_r && byteRdValid) begin
        if (!hiPhase_r) begin
          lowByte_r <= byteRdData;
          hiPhase_r <= 1'b1;
          addr_r <= addr_r + 8'h01;
        end else begin
          // Lower byte address forms the low half
          data_r <= {byteRdData, lowByte_r};
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  byte_order_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wordPort.wordDone |-> wordPort.wordData[7:0] == $past(lowByte_r))
    else $error("word low half not from lower byte");
endmodule : nvm_word_fetch
`default_nettype wire

/* File: lan_nvm_config_loader.sv */
// LAN NVM configuration loader: fetches and applies shared and PCI word groups
// How it works
// - Shared reset fetches words 0x00..0x18 and applies the station address words plus the init, identifier and power words at 0x0A..0x10.
// - PCI reset fetches words 0x0A..0x10 and applies identifiers and power words.
// - First three words go to receive address slot zero, upper byte in high half.
// - Byte 1 bit 0 is first on wire; set means multicast.
// - Byte 1 bit 1 set means locally administered address.
// - Init bit 1 set loads subsystem ID and vendor ID, else defaults kept.
// - Init bit 0 set loads device ID, else built-in ID kept.
// - Subsystem ID reads zero when not loaded.
// - D3cold wake advertised only when aux power and wake enable both set.
// - Wake enable bit 6 permits wake in all states but D3cold (which also needs aux power) and sets wake support field.
// - Selector 0 or 4 returns active-state power, bits 15:8, 100 mW units.
// - Selector 3 or 7 returns sleep-state power bits 4:0, upper bits zero.
// - Power word used only with wake enable; absent word means 0x0702.
`timescale 1ns/1ns
`default_nettype none
`include "nvm_loader_defs.svh"
module lan_nvm_config_loader
  import nvm_loader_pkg::*;
#(
  parameter logic [15:0] SUBSYS_VEN_DEFAULT = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEV_ID_DEFAULT = 16'h5678 // Arbitrary value
)(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sharedResetReq,
  input wire logic pciResetReq,
  input wire logic nvmPresent,
  output logic byteRdReq,
  output logic [7:0] byteRdAddr,
  input wire logic byteRdValid,
  input wire logic [7:0] byteRdData,
  output logic loadBusy,
  output logic [47:0] receive_address_slot_zero,
  output logic addrMulticast,
  output logic addrLocalAdmin,
  output logic [15:0] subsysId,
  output logic [15:0] subsysVendorId,
  output logic [15:0] deviceId,
  output logic power_mgmt_wake_enable,
  output logic [4:0] wake_support_field,
  input wire logic [2:0] powerDataSelect,
  output logic [7:0] powerData
);
  nvm_byte_if wordBus();

  load_state_t state_r;
  load_state_t state_nxt;
  logic pciGroup_r;
  logic [5:0] offset_r;
  logic [15:0] word_r;
  logic [15:0] pciInit_r;
  logic [15:0] power_r;
  logic [47:0] addr_r;
  logic [15:0] subsysId_r;
  logic [15:0] subsysVen_r;
  logic [15:0] devId_r;
  logic [7:0] powerData_r;
  logic [5:0] lastOffset;
  logic groupDone;
  logic wakeEn;
  logic auxPwr;
  logic [7:0] activePower;
  logic [7:0] sleepPower;
  logic [15:0] powerEff;

  nvm_word_fetch fetchUnit (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .wordPort(wordBus.fetch),
    .byteRdReq(byteRdReq),
    .byteRdAddr(byteRdAddr),
    .byteRdValid(byteRdValid),
    .byteRdData(byteRdData)
  );

  function automatic logic isSel(input logic [2:0] sel, input logic [2:0] a,
                                 input logic [2:0] b);
    isSel = (sel == a) || (sel == b);
  endfunction : isSel

  assign wordBus.wordReq = (state_r == ST_REQ);
  assign wordBus.wordOffset = offset_r;
  assign lastOffset = pciGroup_r ? `W_POWER : `W_SHARED_LAST;
  assign groupDone = (offset_r == lastOffset);
  assign loadBusy = (state_r != ST_IDLE);

  assign wakeEn = pciInit_r[`B_WAKE_EN];
  assign auxPwr = pciInit_r[`B_AUXILIARY_POWER_FLAG];
  assign power_mgmt_wake_enable = wakeEn;
  // Cold wake bit only with aux power and wake enable
  assign wake_support_field = !wakeEn ? 5'h00 :
    (auxPwr ? (`WAKE_SUPPORT_ALL | `WAKE_SUPPORT_COLD) : `WAKE_SUPPORT_ALL);
  assign powerEff = wakeEn ? power_r : 16'h0000;
  assign activePower = powerEff[15:8];
  assign sleepPower = {3'h0, powerEff[4:0]};

  assign receive_address_slot_zero = addr_r;
  assign addrMulticast = addr_r[0];
  assign addrLocalAdmin = addr_r[1];
  assign subsysId = subsysId_r;
  assign subsysVendorId = subsysVen_r;
  assign deviceId = devId_r;
  assign powerData = powerData_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if ((sharedResetReq || pciResetReq) && nvmPresent) begin
          state_nxt = ST_REQ;
        end
      end
      ST_REQ: begin
        state_nxt = ST_LO;
      end
      ST_LO: begin
        if (wordBus.wordDone) begin
          state_nxt = ST_APPLY;
        end
      end
      ST_APPLY: begin
        state_nxt = groupDone ? ST_IDLE : ST_REQ;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      pciGroup_r <= 1'b0;
      offset_r <= 6'h00;
      word_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE) begin
        // Shared reset takes precedence when both arrive together
        pciGroup_r <= !sharedResetReq;
        offset_r <= sharedResetReq ? `W_ADDR_LO : `W_PCI_INIT;
      end else if (state_r == ST_APPLY) begin
        offset_r <= offset_r + 6'h01;
      end
      if (wordBus.wordDone) begin
        word_r <= wordBus.wordData;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      addr_r <= 48'h0;
      pciInit_r <= `PCI_INIT_DEFAULT;
      power_r <= `POWER_DEFAULT;
      subsysId_r <= `SUBSYS_ID_DEFAULT;
      subsysVen_r <= SUBSYS_VEN_DEFAULT;
      devId_r <= DEV_ID_DEFAULT;
    end else if (state_r == ST_APPLY) begin
      if (offset_r <= `W_ADDR_HI) begin
        // Word n holds bytes 2n+1 (low half) and 2n+2 (high half)
        addr_r[{offset_r[1:0], 4'h0} +: 16] <= word_r;
      end
      if (offset_r == `W_PCI_INIT) begin
        pciInit_r <= word_r;
      end
      if (offset_r == `W_SUBSYS_ID && pciInit_r[`B_FETCH_SUBSYS]) begin
        subsysId_r <= word_r;
      end
      if (offset_r == `W_SUBSYS_VEN && pciInit_r[`B_FETCH_SUBSYS]) begin
        subsysVen_r <= word_r;
      end
      if (offset_r == `W_DEV_ID && pciInit_r[`B_FETCH_DEV]) begin
        devId_r <= word_r;
      end
      if (offset_r == `W_POWER) begin
        power_r <= word_r;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      powerData_r <= 8'h00;
    end else if (isSel(powerDataSelect, `SEL_D0_A, `SEL_D0_B)) begin
      powerData_r <= activePower;
    end else if (isSel(powerDataSelect, `SEL_D3_A, `SEL_D3_B)) begin
      powerData_r <= sleepPower;
    end else begin
      powerData_r <= 8'h00;
    end
  end

  subsys_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_r == ST_APPLY && offset_r == `W_SUBSYS_ID && !pciInit_r[`B_FETCH_SUBSYS])
    |=> $stable(subsysId_r))
    else $error("subsystem ID changed while not enabled");
  dev_load_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_r == ST_APPLY && offset_r == `W_DEV_ID && pciInit_r[`B_FETCH_DEV])
    |=> devId_r == $past(word_r))
    else $error("device ID not loaded");
  dev_keep_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_r == ST_APPLY && offset_r == `W_DEV_ID && !pciInit_r[`B_FETCH_DEV])
    |=> $stable(devId_r))
    else $error("device ID changed while not enabled");
  cold_wake_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wake_support_field[4] == (auxPwr && wakeEn))
    else $error("cold wake advertised wrongly");
  wake_field_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !wakeEn |-> wake_support_field == 5'h00)
    else $error("wake support set while disabled");
  d0_power_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (powerDataSelect == `SEL_D0_B) |=> powerData == $past(activePower))
    else $error("active power not returned");
  d3_power_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (powerDataSelect == `SEL_D3_A) |=> powerData == {3'h0, $past(powerEff[4:0])})
    else $error("sleep power upper bits not zero");
  addr_slot_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_r == ST_APPLY && offset_r == `W_ADDR_LO)
    |=> addr_r[15:0] == $past(word_r))
    else $error("address word 0 not placed");
  group_end_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_r == ST_APPLY && pciGroup_r && offset_r == `W_POWER) |=> state_r == ST_IDLE)
    else $error("PCI group did not stop at power word");
  shared_end_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_r == ST_APPLY && !pciGroup_r && offset_r == `W_SHARED_LAST)
    |=> state_r == ST_IDLE)
    else $error("shared group did not stop at last word");
endmodule : lan_nvm_config_loader
`default_nettype wire

/* File: nvm_image_model.sv */
// Byte-read model of the shared flash that holds the LAN image
`timescale 1ns/1ns
`default_nettype none
module nvm_image_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic byteRdReq,
  input wire logic [7:0] byteRdAddr,
  input wire logic [3:0] waitCycles,
  output logic byteRdValid,
  output logic [7:0] byteRdData
);
  logic [7:0] mem [0:255];
  logic [3:0] waitCnt_r;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      byteRdValid <= 1'b0;
      waitCnt_r <= 4'h0;
      byteRdData <= 8'ha5;
    end else if (byteRdValid || !byteRdReq) begin
      // Released data toggles so stale bytes never pass for real ones
      byteRdValid <= 1'b0;
      waitCnt_r <= 4'h0;
      byteRdData <= ~byteRdData;
    end else if (waitCnt_r >= waitCycles) begin
      byteRdValid <= 1'b1;
      byteRdData <= mem[byteRdAddr];
    end else begin
      waitCnt_r <= waitCnt_r + 4'h1;
      byteRdData <= ~byteRdData;
    end
  end
endmodule : nvm_image_model
`default_nettype wire

/* File: tb_lan_nvm_config_loader.sv */
// Self-checking testbench for the LAN NVM configuration loader
`timescale 1ns/1ns
`default_nettype none
module tb_lan_nvm_config_loader;
  import nvm_loader_pkg::*;
  localparam logic [15:0] VEN_DEF = 16'h1234; // Arbitrary value
  localparam logic [15:0] DEV_DEF = 16'h5678; // Arbitrary value
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic sharedResetReq = 1'b0;
  logic pciResetReq = 1'b0;
  logic nvmPresent = 1'b1;
  logic [2:0] powerDataSelect = 3'h0;
  logic [3:0] waitCycles = 4'h0;
  logic byteRdReq, byteRdValid, loadBusy, addrMulticast, addrLocalAdmin, power_mgmt_wake_enable;
  logic [7:0] byteRdAddr, byteRdData, powerData, expAddr;
  logic [47:0] receive_address_slot_zero;
  logic [15:0] subsysId, subsysVendorId, deviceId;
  logic [4:0] wake_support_field;
  int n_mismatch = 0;
  int checked = 0;
  int nBytes = 0;
  int cycles = 0;

  lan_nvm_config_loader #(.SUBSYS_VEN_DEFAULT(VEN_DEF), .DEV_ID_DEFAULT(DEV_DEF)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .sharedResetReq(sharedResetReq),
    .pciResetReq(pciResetReq), .nvmPresent(nvmPresent), .byteRdReq(byteRdReq),
    .byteRdAddr(byteRdAddr), .byteRdValid(byteRdValid), .byteRdData(byteRdData),
    .loadBusy(loadBusy), .receive_address_slot_zero(receive_address_slot_zero),
    .addrMulticast(addrMulticast), .addrLocalAdmin(addrLocalAdmin), .subsysId(subsysId),
    .subsysVendorId(subsysVendorId), .deviceId(deviceId),
    .power_mgmt_wake_enable(power_mgmt_wake_enable), .wake_support_field(wake_support_field),
    .powerDataSelect(powerDataSelect), .powerData(powerData));
  nvm_image_model mdl (.clk_sys(clk_sys), .resetn(resetn), .byteRdReq(byteRdReq),
    .byteRdAddr(byteRdAddr), .waitCycles(waitCycles), .byteRdValid(byteRdValid),
    .byteRdData(byteRdData));

  always #10 clk_sys = ~clk_sys;

  // Byte requests checked mid-cycle, where the model's answer stands settled
  always @(negedge clk_sys) begin
    cycles <= cycles + 1;
    if (byteRdValid === 1'b1 && byteRdReq === 1'b1) begin
      cmp("byteRdAddr", expAddr, byteRdAddr);
      expAddr = expAddr + 8'h01;
      nBytes++;
    end
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic put_word(input logic [5:0] off, input logic [15:0] val);
    mdl.mem[{off, 1'b0}] = val[7:0];
    mdl.mem[{off, 1'b1}] = val[15:8];
  endtask : put_word

  task automatic seal_image();
    logic [15:0] sum;
    int w;
    sum = 16'h0000;
    for (w = 0; w < 63; w++) begin
      sum = sum + {mdl.mem[2 * w + 1], mdl.mem[2 * w]};
    end
    put_word(6'h3f, 16'h0000 - sum);
  endtask : seal_image

  task automatic load_pci(input logic [15:0] init, input logic [15:0] sub,
                          input logic [15:0] ven, input logic [15:0] dev,
                          input logic [15:0] pwr);
    put_word(6'h0a, init);
    put_word(6'h0b, sub);
    put_word(6'h0c, ven);
    put_word(6'h0d, dev);
    put_word(6'h10, pwr);
    seal_image();
  endtask : load_pci

  task automatic do_reset();
    @(negedge clk_sys);
    resetn = 1'b0;
    repeat (6) @(negedge clk_sys);
    resetn = 1'b1;
  endtask : do_reset

  task automatic run_group(input logic isShared, input logic [7:0] first, input int nb);
    int i;
    @(negedge clk_sys);
    expAddr = first;
    nBytes = 0;
    sharedResetReq = isShared;
    pciResetReq = ~isShared;
    @(negedge clk_sys);
    sharedResetReq = 1'b0;
    pciResetReq = 1'b0;
    cmp("loadBusy", 48'h1, {47'h0, loadBusy});
    for (i = 0; i < 3000 && loadBusy === 1'b1; i++) begin
      @(negedge clk_sys);
    end
    cmp("byte count", nb, nBytes);
  endtask : run_group

  task automatic check_addr(input logic [47:0] exp);
    cmp("receive_address_slot_zero", exp, receive_address_slot_zero);
    cmp("addrMulticast", exp[0], addrMulticast);
    cmp("addrLocalAdmin", exp[1], addrLocalAdmin);
  endtask : check_addr

  task automatic check_pci(input logic [15:0] init, input logic [15:0] sub,
                           input logic [15:0] ven, input logic [15:0] dev,
                           input logic [15:0] pwr);
    int s;
    logic [7:0] e;
    cmp("subsysId", sub, subsysId);
    cmp("subsysVendorId", ven, subsysVendorId);
    cmp("deviceId", dev, deviceId);
    cmp("power_mgmt_wake_enable", init[6], power_mgmt_wake_enable);
    cmp("wake_support_field", init[6] ? (init[7] ? 5'h1f : 5'h0f) : 5'h00,
        wake_support_field);
    for (s = 0; s < 8; s++) begin
      @(negedge clk_sys);
      powerDataSelect = s[2:0];
      @(negedge clk_sys);
      e = (s == 0 || s == 4) ? pwr[15:8] : (s == 3 || s == 7) ? {3'h0, pwr[4:0]} : 8'h00;
      cmp("powerData", init[6] ? e : 8'h00, powerData);
    end
  endtask : check_pci

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    int i;
    for (i = 0; i < 256; i++) begin
      mdl.mem[i] = 8'(i) ^ 8'h5a;
    end
    do_reset();
    check_pci(16'h10c3, 16'h0000, VEN_DEF, DEV_DEF, 16'h0702);
    // Missing image: request must be ignored
    nvmPresent = 1'b0;
    pciResetReq = 1'b1;
    @(negedge clk_sys);
    pciResetReq = 1'b0;
    @(negedge clk_sys);
    cmp("loadBusy", 48'h0, {47'h0, loadBusy});
    nvmPresent = 1'b1;
    check_pci(16'h10c3, 16'h0000, VEN_DEF, DEV_DEF, 16'h0702);
    // Full image, slow memory
    put_word(6'h00, 16'h5e03);
    put_word(6'h01, 16'h2211);
    put_word(6'h02, 16'h4433);
    load_pci(16'h10c3, 16'h4455, 16'h6677, 16'h8899, 16'h1a05);
    waitCycles = 4'h3;
    run_group(1'b1, 8'h00, 50);
    check_addr(48'h443322115e03);
    run_group(1'b0, 8'h14, 14);
    check_pci(16'h10c3, 16'h4455, 16'h6677, 16'h8899, 16'h1a05);
    // No loads, wake off, aux on
    do_reset();
    load_pci(16'h1080, 16'h4455, 16'h6677, 16'h8899, 16'h1a05);
    run_group(1'b0, 8'h14, 14);
    check_pci(16'h1080, 16'h0000, VEN_DEF, DEV_DEF, 16'h1a05);
    // Device ID only, wake on, aux off, fast memory
    do_reset();
    load_pci(16'h1041, 16'h4455, 16'h6677, 16'h8899, 16'h1a05);
    waitCycles = 4'h0;
    run_group(1'b0, 8'h14, 14);
    check_pci(16'h1041, 16'h0000, VEN_DEF, DEV_DEF ^ DEV_DEF ^ 16'h8899, 16'h1a05);
    // Unicast, locally administered address
    put_word(6'h00, 16'h5e02);
    seal_image();
    run_group(1'b1, 8'h00, 50);
    check_addr(48'h443322115e02);
    report_and_stop();
  end
endmodule : tb_lan_nvm_config_loader
`default_nettype wire
